// [hdl/fhsm_regs.vh]
// register offsets, fields and reset values of the fax handshake status monitor
// assumes an apb master with 32-bit data, byte addresses = 4 x index
`ifndef FHSM_REGS_VH
`define FHSM_REGS_VH
`define FHSM_IDX_RX_STATE 12'h016
`define FHSM_IDX_TX_STATE 12'h017
`define FHSM_IDX_FIRST_CF 12'h304
`define FHSM_IDX_ALLOWED_CF 12'h32a
`define FHSM_IDX_RX_MASK 12'h370
`define FHSM_IDX_TX_MASK 12'h371
`define FHSM_IDX_OPTION 12'h38f
`define FHSM_IDX_V8_CTRL 12'h305
`define FHSM_IDX_CONTROL 12'h3c0
`define FHSM_IDX_STATUS 12'h3c1
`define FHSM_IDX_RX_DATA 12'h3c2
`define FHSM_RST_FIRST_CF 8'hc0
`define FHSM_RST_ALLOWED_CF 8'h40
`define FHSM_RST_V8_CTRL 8'h08
`define FHSM_RST_OPTION 8'h00
`define FHSM_RST_MASK 8'h00
`define FHSM_RST_STATE 8'h00
`define FHSM_BIT_V8_OCTET_HIDE 3
`define FHSM_BIT_CM_NO_ANS 3
`define FHSM_BIT_ORIGINATE 0
`define FHSM_BIT_NEW_CONFIG 1
`define FHSM_BIT_NOTIFY_RX 0
`define FHSM_BIT_NOTIFY_TX 1
`define FHSM_BIT_OCTET_READY 2
`define FHSM_PH1 3'b000
`define FHSM_PH2 3'b001
`define FHSM_PH3 3'b010
`define FHSM_PH45 3'b100
`define FHSM_PH6 3'b101
`endif

// [hdl/fhsm_top.v]
// fax handshake status monitor: state bytes, change notify, host option registers
// assumes pump state reports arrive from logic on pclk with a one-cycle valid strobe
// What this block does
// - 305h bit3 clear shows v8 octets
// - state bytes: phase 7-5, state 4-0
// - receiver phase codes 0,1,2,4,5
// - transmitter uses same phase codes
// - byte change raises masked notify
// - answer receiver phase 1 states 00-03
// - answer receiver phase 2 state codes
// - control channel tx and rx codes
`include "fhsm_regs.vh"
module fhsm_top
(
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [13:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire pump_rx_valid,
    input wire [7:0] pump_rx_state,
    input wire pump_tx_valid,
    input wire [7:0] pump_tx_state,
    input wire pump_octet_valid,
    input wire [7:0] pump_octet,
    output reg new_status_notify,
    output reg new_config_request,
    output reg originate_select,
    output reg [7:0] config_code
);
    reg [7:0] rx_handshake_state;
    reg [7:0] tx_handshake_state;
    reg [7:0] first_call_function;
    reg [7:0] allowed_call_functions;
    reg [7:0] rx_state_change_mask;
    reg [7:0] tx_state_change_mask;
    reg [7:0] handshake_option_bits;
    reg [7:0] v8_control;
    reg [7:0] receive_data_buffer;
    wire rx_changed;
    wire tx_changed;
    wire octet_ready;
    wire [2:0] flag_set;
    wire [2:0] flag_clr;
    wire [2:0] status_flags;
    wire rx_mask_on;
    wire tx_mask_on;
    genvar fi;
    reg [31:0] next_prdata;
    reg next_slverr;
    wire [11:0] idx;
    wire wr_acc;
    wire rd_acc;
    wire rx_ok;
    wire tx_ok;
    wire rx_set;
    wire tx_set;
    wire oct_set;
    wire clr_rx;
    wire clr_tx;
    wire clr_oct;

    // receiver codes used by either side; every other code is dropped
    function rx_code_legal;
        input [7:0] code;
        begin
            case (code)
                8'h00: rx_code_legal = 1'b1;
                8'h01: rx_code_legal = 1'b1;
                8'h02: rx_code_legal = 1'b1;
                8'h03: rx_code_legal = 1'b1;
                8'h20: rx_code_legal = 1'b1;
                8'h22: rx_code_legal = 1'b1;
                8'h23: rx_code_legal = 1'b1;
                8'h24: rx_code_legal = 1'b1;
                8'h25: rx_code_legal = 1'b1;
                8'h26: rx_code_legal = 1'b1;
                8'h27: rx_code_legal = 1'b1;
                8'h28: rx_code_legal = 1'b1;
                8'h29: rx_code_legal = 1'b1;
                8'h2a: rx_code_legal = 1'b1;
                8'h2c: rx_code_legal = 1'b1;
                8'h2e: rx_code_legal = 1'b1;
                8'h2f: rx_code_legal = 1'b1;
                8'h40: rx_code_legal = 1'b1;
                8'h41: rx_code_legal = 1'b1;
                8'h46: rx_code_legal = 1'b1;
                8'h47: rx_code_legal = 1'b1;
                8'h80: rx_code_legal = 1'b1;
                8'h81: rx_code_legal = 1'b1;
                8'h82: rx_code_legal = 1'b1;
                8'h83: rx_code_legal = 1'b1;
                8'h84: rx_code_legal = 1'b1;
                8'h86: rx_code_legal = 1'b1;
                8'h87: rx_code_legal = 1'b1;
                8'h8b: rx_code_legal = 1'b1;
                8'ha0: rx_code_legal = 1'b1;
                8'ha1: rx_code_legal = 1'b1;
                8'ha2: rx_code_legal = 1'b1;
                8'ha3: rx_code_legal = 1'b1;
                default: rx_code_legal = 1'b0;
            endcase
        end
    endfunction

    // transmitter codes used by either side; every other code is dropped
    function tx_code_legal;
        input [7:0] code;
        begin
            case (code)
                8'h00: tx_code_legal = 1'b1;
                8'h01: tx_code_legal = 1'b1;
                8'h02: tx_code_legal = 1'b1;
                8'h03: tx_code_legal = 1'b1;
                8'h04: tx_code_legal = 1'b1;
                8'h05: tx_code_legal = 1'b1;
                8'h20: tx_code_legal = 1'b1;
                8'h21: tx_code_legal = 1'b1;
                8'h22: tx_code_legal = 1'b1;
                8'h24: tx_code_legal = 1'b1;
                8'h25: tx_code_legal = 1'b1;
                8'h26: tx_code_legal = 1'b1;
                8'h28: tx_code_legal = 1'b1;
                8'h2a: tx_code_legal = 1'b1;
                8'h2c: tx_code_legal = 1'b1;
                8'h40: tx_code_legal = 1'b1;
                8'h44: tx_code_legal = 1'b1;
                8'h45: tx_code_legal = 1'b1;
                8'h46: tx_code_legal = 1'b1;
                8'h47: tx_code_legal = 1'b1;
                8'h80: tx_code_legal = 1'b1;
                8'h81: tx_code_legal = 1'b1;
                8'h82: tx_code_legal = 1'b1;
                8'h83: tx_code_legal = 1'b1;
                8'h84: tx_code_legal = 1'b1;
                8'h87: tx_code_legal = 1'b1;
                8'h88: tx_code_legal = 1'b1;
                8'h89: tx_code_legal = 1'b1;
                8'h8a: tx_code_legal = 1'b1;
                8'ha0: tx_code_legal = 1'b1;
                8'ha4: tx_code_legal = 1'b1;
                8'ha5: tx_code_legal = 1'b1;
                8'ha6: tx_code_legal = 1'b1;
                8'ha7: tx_code_legal = 1'b1;
                default: tx_code_legal = 1'b0;
            endcase
        end
    endfunction

    assign idx = paddr[13:2];
    assign wr_acc = psel & penable & pwrite & pready;
    assign rd_acc = psel & penable & ~pwrite & pready;
    assign rx_ok = pump_rx_valid & rx_code_legal(pump_rx_state);
    assign tx_ok = pump_tx_valid & tx_code_legal(pump_tx_state);
    assign rx_set = rx_ok & (pump_rx_state != rx_handshake_state);
    assign tx_set = tx_ok & (pump_tx_state != tx_handshake_state);
    assign oct_set = pump_octet_valid & ~v8_control[`FHSM_BIT_V8_OCTET_HIDE];
    assign clr_rx = wr_acc && idx == `FHSM_IDX_STATUS && pwdata[`FHSM_BIT_NOTIFY_RX];
    assign clr_tx = wr_acc && idx == `FHSM_IDX_STATUS && pwdata[`FHSM_BIT_NOTIFY_TX];
    assign clr_oct = rd_acc && idx == `FHSM_IDX_RX_DATA;
    assign flag_set = {oct_set, tx_set, rx_set};
    assign flag_clr = {clr_oct, clr_tx, clr_rx};
    assign rx_changed = status_flags[`FHSM_BIT_NOTIFY_RX];
    assign tx_changed = status_flags[`FHSM_BIT_NOTIFY_TX];
    assign octet_ready = status_flags[`FHSM_BIT_OCTET_READY];
    assign rx_mask_on = |rx_state_change_mask;
    assign tx_mask_on = |tx_state_change_mask;

    // read mux and unmapped decode
    always @*
    begin
        next_prdata = 32'h0000_0000;
        next_slverr = 1'b0;
        if (idx == `FHSM_IDX_RX_STATE)
            next_prdata[7:0] = rx_handshake_state;
        else if (idx == `FHSM_IDX_TX_STATE)
            next_prdata[7:0] = tx_handshake_state;
        else if (idx == `FHSM_IDX_FIRST_CF)
            next_prdata[7:0] = first_call_function;
        else if (idx == `FHSM_IDX_ALLOWED_CF)
            next_prdata[7:0] = allowed_call_functions;
        else if (idx == `FHSM_IDX_RX_MASK)
            next_prdata[7:0] = rx_state_change_mask;
        else if (idx == `FHSM_IDX_TX_MASK)
            next_prdata[7:0] = tx_state_change_mask;
        else if (idx == `FHSM_IDX_OPTION)
            next_prdata[7:0] = handshake_option_bits;
        else if (idx == `FHSM_IDX_V8_CTRL)
            next_prdata[7:0] = v8_control;
        else if (idx == `FHSM_IDX_CONTROL)
            next_prdata[15:0] = {config_code, 6'h00, new_config_request, originate_select};
        else if (idx == `FHSM_IDX_STATUS)
            next_prdata[2:0] = {octet_ready, tx_changed, rx_changed};
        else if (idx == `FHSM_IDX_RX_DATA)
            next_prdata[7:0] = receive_data_buffer;
        else
            next_slverr = 1'b1;
    end

    // apb slave: one wait state, answer registered
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel & penable & ~pready;
            prdata <= (psel & penable & ~pready & ~pwrite) ? next_prdata : 32'h0000_0000;
            pslverr <= psel & penable & ~pready & next_slverr;
        end
    end

    // host-written registers
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            first_call_function <= `FHSM_RST_FIRST_CF;
            allowed_call_functions <= `FHSM_RST_ALLOWED_CF;
            rx_state_change_mask <= `FHSM_RST_MASK;
            tx_state_change_mask <= `FHSM_RST_MASK;
            handshake_option_bits <= `FHSM_RST_OPTION;
            v8_control <= `FHSM_RST_V8_CTRL;
            config_code <= 8'h00;
            originate_select <= 1'b0;
            new_config_request <= 1'b0;
        end
        else if (wr_acc)
        begin
            if (idx == `FHSM_IDX_FIRST_CF)
                first_call_function <= pwdata[7:0];
            else if (idx == `FHSM_IDX_ALLOWED_CF)
                allowed_call_functions <= pwdata[7:0];
            else if (idx == `FHSM_IDX_RX_MASK)
                rx_state_change_mask <= pwdata[7:0];
            else if (idx == `FHSM_IDX_TX_MASK)
                tx_state_change_mask <= pwdata[7:0];
            else if (idx == `FHSM_IDX_OPTION)
                handshake_option_bits <= pwdata[7:0];
            else if (idx == `FHSM_IDX_V8_CTRL)
                v8_control <= pwdata[7:0];
            else if (idx == `FHSM_IDX_CONTROL)
            begin
                originate_select <= pwdata[`FHSM_BIT_ORIGINATE];
                new_config_request <= pwdata[`FHSM_BIT_NEW_CONFIG];
                config_code <= pwdata[15:8];
            end
        end
    end

    // state bytes, notify pulse and octet buffer; only legal codes load a state byte
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_handshake_state <= `FHSM_RST_STATE;
            tx_handshake_state <= `FHSM_RST_STATE;
            receive_data_buffer <= 8'h00;
            new_status_notify <= 1'b0;
        end
        else
        begin
            if (rx_ok)
                rx_handshake_state <= pump_rx_state;
            if (tx_ok)
                tx_handshake_state <= pump_tx_state;
            if (oct_set)
                receive_data_buffer <= pump_octet;
            new_status_notify <= (rx_set & rx_mask_on) | (tx_set & tx_mask_on);
        end
    end

    // sticky status flags; a set in the same cycle as a clear wins
    generate
        for (fi = 0; fi < 3; fi = fi + 1)
        begin : g_flag
            reg flag;
            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    flag <= 1'b0;
                else
                    flag <= flag_set[fi] | (flag & ~flag_clr[fi]);
            end
            assign status_flags[fi] = flag;
        end
    endgenerate
endmodule // fhsm_top

// [verification/fhsm_chk.sv]
// checker: apb answer timing and status notify of the monitor
// assumes a bind to fhsm_top
module fhsm_chk
(
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire pready,
    input wire pslverr,
    input wire [31:0] prdata,
    input wire pump_rx_valid,
    input wire pump_tx_valid,
    input wire new_status_notify,
    input wire new_config_request,
    input wire originate_select,
    input wire [7:0] config_code
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_RDY_NEXT: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    AST_RDY_ONE: assert property (pready |=> !pready)
        else $error("pready too long");
    AST_RDY_REQ: assert property (pready |-> psel && penable && $past(penable))
        else $error("pready without access");
    AST_ERR_ZERO: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("bad refused answer");
    AST_IDLE_ZERO: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    AST_HIGH_ZERO: assert property (pready |-> prdata[31:16] == 16'h0)
        else $error("upper read bits set");
    AST_NOTIFY_CAUSE: assert property (new_status_notify
        |-> $past(pump_rx_valid) || $past(pump_tx_valid))
        else $error("notify without state byte");
    AST_CTRL_HOLD: assert property (!(psel && penable && pwrite && pready)
        |=> $stable({config_code, new_config_request, originate_select}))
        else $error("control changed without write");
    cover property (new_status_notify);
    cover property (pslverr);
    cover property (pready && pwrite);
endmodule // fhsm_chk

// [verification/fhsm_host.sv]
// host model: apb master of the monitor's registers
// assumes pready answers; waits are cut only by the bench timeout
module fhsm_host
(
    input wire pclk,
    input wire pready,
    input wire pslverr,
    input wire [31:0] prdata,
    output logic psel = 1'b0,
    output logic penable = 1'b0,
    output logic pwrite = 1'b0,
    output logic [13:0] paddr = 14'h0,
    output logic [31:0] pwdata = 32'h0
);
    timeunit 1ns;
    timeprecision 1ps;
    task automatic xfer(input logic wr, input logic [11:0] idx, input logic [31:0] wd,
        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule // fhsm_host

// [verification/fhsm_top_tb.sv]
// self-checking bench of the handshake status monitor
// assumes the host model speaks apb; the bench drives the pump strobes
`include "fhsm_regs.vh"
module fhsm_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    wire psel, penable, pwrite, pready, pslverr, notify, new_cfg, orig;
    wire [13:0] paddr;
    wire [31:0] pwdata, prdata;
    wire [7:0] cfg;
    logic rxv = 1'b0, txv = 1'b0, octv = 1'b0;
    logic [7:0] rxs = 8'h0, txs = 8'h0, oct = 8'h0;
    logic [31:0] rd;
    logic err;
    int miscompares = 0, cmp_count = 0, cycles = 0;
    always #4 pclk = ~pclk;
    fhsm_top u_fhsm_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pump_rx_valid(rxv), .pump_rx_state(rxs), .pump_tx_valid(txv),
        .pump_tx_state(txs), .pump_octet_valid(octv), .pump_octet(oct),
        .new_status_notify(notify), .new_config_request(new_cfg),
        .originate_select(orig), .config_code(cfg));
    fhsm_host u_fhsm_host (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [11:0] idx, input logic [31:0] d);
        u_fhsm_host.xfer(1'b1, idx, d, rd, err);
        #1;
    endtask
    task automatic rdc(input string what, input logic [11:0] idx, input logic [31:0] exp);
        u_fhsm_host.xfer(1'b0, idx, 32'h0, rd, err);
        check(what, exp, rd);
    endtask
    task automatic pump(input logic tx, input logic [7:0] code, input logic exp_n);
        @(posedge pclk);
        rxv <= !tx;
        txv <= tx;
        rxs <= code;
        txs <= code;
        @(posedge pclk);
        rxv <= 1'b0;
        txv <= 1'b0;
        #1;
        check("notify", exp_n, notify);
    endtask
    task automatic put_octet(input logic [7:0] d);
        @(posedge pclk);
        octv <= 1'b1;
        oct <= d;
        @(posedge pclk);
        octv <= 1'b0;
    endtask
    task automatic t_reset;
        rdc("first_cf", `FHSM_IDX_FIRST_CF, 32'hc0);
        rdc("allowed_cf", `FHSM_IDX_ALLOWED_CF, 32'h40);
        rdc("option", `FHSM_IDX_OPTION, 32'h0);
        rdc("rx_state", `FHSM_IDX_RX_STATE, 32'h0);
        rdc("unmapped", 12'h100, 32'h0);
        check("slverr", 32'h1, err);
        $display("reset test done");
    endtask
    task automatic t_host;
        wr(`FHSM_IDX_ALLOWED_CF, 32'h30);
        rdc("allowed_cf", `FHSM_IDX_ALLOWED_CF, 32'h30);
        wr(`FHSM_IDX_ALLOWED_CF, 32'h20);
        wr(`FHSM_IDX_FIRST_CF, 32'ha8);
        rdc("first_cf", `FHSM_IDX_FIRST_CF, 32'ha8);
        wr(`FHSM_IDX_CONTROL, 32'haa03);
        wr(`FHSM_IDX_OPTION, 32'h08);
        rdc("option", `FHSM_IDX_OPTION, 32'h08);
        check("control", 32'haa03, {cfg, 6'h0, new_cfg, orig});
        wr(`FHSM_IDX_CONTROL, 32'haa02);
        check("originate", 32'h0, orig);
        wr(`FHSM_IDX_CONTROL, 32'haa03);
        check("originate", 32'h1, orig);
        $display("host test done");
    endtask
    task automatic t_state;
        wr(`FHSM_IDX_RX_MASK, 32'hff);
        pump(1'b0, 8'h26, 1'b1);
        pump(1'b0, 8'h21, 1'b0);
        pump(1'b0, 8'h60, 1'b0);
        rdc("rx_state", `FHSM_IDX_RX_STATE, 32'h26);
        pump(1'b0, 8'h03, 1'b1);
        pump(1'b1, 8'h84, 1'b0);
        rdc("tx_state", `FHSM_IDX_TX_STATE, 32'h84);
        wr(`FHSM_IDX_TX_MASK, 32'h01);
        pump(1'b1, 8'h88, 1'b1);
        pump(1'b1, 8'h88, 1'b0);
        pump(1'b1, 8'h86, 1'b0);
        pump(1'b1, 8'h23, 1'b0);
        rdc("tx_state", `FHSM_IDX_TX_STATE, 32'h88);
        rdc("status", `FHSM_IDX_STATUS, 32'h3);
        wr(`FHSM_IDX_STATUS, 32'h3);
        rdc("status", `FHSM_IDX_STATUS, 32'h0);
        $display("state test done");
    endtask
    task automatic t_octet;
        put_octet(8'h33);
        rdc("status", `FHSM_IDX_STATUS, 32'h0);
        wr(`FHSM_IDX_V8_CTRL, 32'h0);
        put_octet(8'h5a);
        rdc("status", `FHSM_IDX_STATUS, 32'h4);
        rdc("octet", `FHSM_IDX_RX_DATA, 32'h5a);
        rdc("status", `FHSM_IDX_STATUS, 32'h0);
        $display("octet test done");
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_host();
        t_state();
        t_octet();
        print_verdict();
    end
    always @(posedge pclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            miscompares++;
            print_verdict();
        end
    end
endmodule // fhsm_top_tb
bind fhsm_top fhsm_chk u_fhsm_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .pump_rx_valid(pump_rx_valid), .pump_tx_valid(pump_tx_valid),
    .new_status_notify(new_status_notify), .new_config_request(new_config_request),
    .originate_select(originate_select), .config_code(config_code));
